// [rtl/bsu_unit.sv]
// Buffer sync unit: guards one buffer between network master and local host.
// Assumes accesses arrive one byte at a time on the link, on one clock.
//
// Notes on behaviour
// - Header opens with length, then originator address
// - Channel reserved zero, priority zero to three
// - Four-bit protocol type codes
// - Three-bit sequence counter, then zero bit
// - Interrupt on completed write or read
// - Watchdog pulse after completed write
// - Status always shows current buffer state
// - Optional latch pulse on completed access
// - Length one or zero bypasses buffering
// - Length one still gives triggers, interrupts
// - Prefer buffered mode for single-byte triggers
// - Output bytes need one buffered unit each
// - Zero length behaves disabled, no events
// - Repeat request bit1 activate, ack bit1 host
// - Master activation change sets event bit
// - Host rewrites buffer, toggles ack; master reads
// - Host deactivate resets state, needs write first
// - Deactivated buffer blocks reads and writes
// - Blocked master access leaves counter unchanged
// - Start address opens, end address completes once
// - Full handshake buffer blocks writes until read
// - Master completions apply only after good check
// - Config block of eight registers at base
`timescale 1ns/1ps
`include "bsu_defines.svh"
module bsu_unit #(
  parameter int DEPTH = 64
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  output logic o_wdog_trig,
  output logic o_latch_evt,
  bsu_link_if.device lnk
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [15:0] start;
    logic [15:0] len;
    logic [7:0] ctrl;
    logic [7:0] act;
    logic [7:0] hctl;
    logic wr_evt;
    logic rd_evt;
    logic full;
    logic [1:0] wbuf;
    logic [1:0] last;
    logic [1:0] rbuf;
    logic m_open;
    logic h_open;
    logic m_end_used;
    logic pend_wr;
    logic pend_rd;
    logic act_chg;
    logic ack;
    logic ok;
    logic [7:0] rdata;
    logic wdog;
    logic latch;
  } unit_st_t;

  unit_st_t s;
  unit_st_t next_s;
  logic is_master;
  logic in_buf;
  logic active;
  logic prod;
  logic is_open;
  logic is_end;
  logic [1:0] bidx;
  logic [15:0] phys;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // The one buffer of three held by neither of the other two roles
  function automatic logic [1:0] free_idx(input logic [1:0] a, input logic [1:0] b);
    return 2'h3 - a - b;
  endfunction

  // Effects of a finished buffer pass; single-byte units skip the buffering
  function automatic unit_st_t finish(input unit_st_t st, input logic is_wr);
    unit_st_t r;
    r = st;
    if (is_wr) begin
      r.wr_evt = 1'b1;
      r.wdog = st.ctrl[`BSU_CTRL_WDG];
      if (st.len > 16'h0001) begin
        if (st.ctrl[`BSU_CTRL_MBX]) begin
          r.full = 1'b1;
        end else begin
          r.last = st.wbuf;
          r.wbuf = free_idx(st.rbuf, st.wbuf);
        end
      end
    end else begin
      r.rd_evt = 1'b1;
      if (st.len > 16'h0001 && st.ctrl[`BSU_CTRL_MBX]) begin
        r.full = 1'b0;
      end
    end
    r.latch = st.ctrl[`BSU_CTRL_LAT];
    return r;
  endfunction

  // Current buffer state as software sees it
  function automatic logic [7:0] status(input unit_st_t st);
    logic [7:0] v;
    v = 8'h00;
    v[`BSU_STAT_WR] = st.wr_evt;
    v[`BSU_STAT_RD] = st.rd_evt;
    v[`BSU_STAT_FULL] = st.full;
    v[`BSU_STAT_LAST +: 2] = st.last;
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  assign is_master = (lnk.who == bsu_pkg::SRC_MASTER);
  assign in_buf = (s.len != 16'h0000) && (lnk.addr >= s.start) &&
                  (lnk.addr < s.start + s.len);
  assign active = s.act[`BSU_ACT_EN] && !s.hctl[`BSU_HCTL_DEACT];
  assign prod = (is_master == s.ctrl[`BSU_CTRL_MWR]);
  assign is_open = is_master ? s.m_open : s.h_open;
  assign is_end = (lnk.addr == s.start + s.len - 16'h0001);
  assign bidx = s.ctrl[`BSU_CTRL_MBX] ? 2'h0 : (prod ? s.wbuf : s.rbuf);
  assign phys = lnk.addr + 16'({14'h0000, bidx} * s.len);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Request answered one cycle later; the frame commit runs after the
  // access so that an event set always beats a status-read clear
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.wdog = 1'b0;
    next_s.latch = 1'b0;
    if (lnk.req) begin
      next_s.ack = 1'b1;
      next_s.ok = 1'b1;
      next_s.rdata = 8'h00;
      if (lnk.addr[15:3] == 13'(`BSU_CFG_BASE >> 3)) begin
        unique case (lnk.addr[2:0])
          `BSU_OFS_START_LO: next_s.rdata = s.start[7:0];
          `BSU_OFS_START_HI: next_s.rdata = s.start[15:8];
          `BSU_OFS_LEN_LO: next_s.rdata = s.len[7:0];
          `BSU_OFS_LEN_HI: next_s.rdata = s.len[15:8];
          `BSU_OFS_CTRL: next_s.rdata = s.ctrl;
          `BSU_OFS_STAT: next_s.rdata = status(s);
          `BSU_OFS_ACT: next_s.rdata = s.act;
          `BSU_OFS_HCTL: next_s.rdata = s.hctl;
        endcase
        if (!lnk.wr && lnk.addr[2:0] == `BSU_OFS_STAT) begin
          next_s.wr_evt = 1'b0;
          next_s.rd_evt = 1'b0;
        end
        if (!lnk.wr && !is_master && lnk.addr[2:0] == `BSU_OFS_ACT) begin
          next_s.act_chg = 1'b0;
        end
        if (lnk.wr && is_master) begin
          unique case (lnk.addr[2:0])
            `BSU_OFS_START_LO: next_s.start[7:0] = lnk.wdata;
            `BSU_OFS_START_HI: next_s.start[15:8] = lnk.wdata;
            `BSU_OFS_LEN_LO: next_s.len[7:0] = lnk.wdata;
            `BSU_OFS_LEN_HI: next_s.len[15:8] = lnk.wdata;
            `BSU_OFS_CTRL: next_s.ctrl = lnk.wdata;
            `BSU_OFS_ACT: next_s.act = lnk.wdata;
            default: next_s.ok = 1'b0;
          endcase
          // Any toggle counts, so the request has no fixed polarity
          if (lnk.addr[2:0] == `BSU_OFS_ACT && lnk.wdata != s.act) begin
            next_s.act_chg = 1'b1;
          end
        end
        if (lnk.wr && !is_master && lnk.addr[2:0] == `BSU_OFS_HCTL) begin
          next_s.hctl = lnk.wdata;
          if (lnk.wdata[`BSU_HCTL_DEACT]) begin
            next_s.full = 1'b0;
            next_s.wbuf = `BSU_WBUF_RST;
            next_s.last = `BSU_LAST_EMPTY;
            next_s.rbuf = `BSU_RBUF_RST;
            next_s.m_open = 1'b0;
            next_s.h_open = 1'b0;
            next_s.pend_wr = 1'b0;
            next_s.pend_rd = 1'b0;
            next_s.wr_evt = 1'b0;
            next_s.rd_evt = 1'b0;
          end
        end
      end else if (!in_buf) begin
        // Outside the buffer, or length zero: plain memory
        if (lnk.wr) begin
          next_s.mem[lnk.addr[AW-1:0]] = lnk.wdata;
        end
        next_s.rdata = s.mem[lnk.addr[AW-1:0]];
      end else if (!active) begin
        next_s.ok = 1'b0;
      end else if (s.len == 16'h0001) begin
        // Single byte passes straight through but still reports
        if (lnk.wr) begin
          next_s.mem[lnk.addr[AW-1:0]] = lnk.wdata;
        end
        next_s.rdata = s.mem[lnk.addr[AW-1:0]];
        if (prod == lnk.wr) begin
          if (is_master) begin
            next_s.pend_wr = s.pend_wr | lnk.wr;
            next_s.pend_rd = s.pend_rd | !lnk.wr;
          end else begin
            next_s = finish(next_s, lnk.wr);
          end
        end
      end else if (prod != lnk.wr) begin
        next_s.ok = 1'b0;
      end else if (s.ctrl[`BSU_CTRL_MBX] && (prod ? s.full : !s.full)) begin
        next_s.ok = 1'b0;
      end else if (!is_open && lnk.addr != s.start) begin
        next_s.ok = 1'b0;
      end else if (is_master && is_end && s.m_end_used) begin
        next_s.ok = 1'b0;
      end else begin
        if (lnk.wr) begin
          next_s.mem[phys[AW-1:0]] = lnk.wdata;
        end else begin
          next_s.rdata = s.mem[phys[AW-1:0]];
        end
        // Reader takes the newest complete buffer when it opens
        if (lnk.addr == s.start && !prod && !s.ctrl[`BSU_CTRL_MBX] &&
            s.last != `BSU_LAST_EMPTY) begin
          next_s.rbuf = s.last;
          next_s.rdata = s.mem[AW'(lnk.addr + 16'({14'h0000, s.last} * s.len))];
        end
        if (is_master) begin
          next_s.m_open = !is_end;
          if (is_end) begin
            next_s.m_end_used = 1'b1;
            next_s.pend_wr = s.pend_wr | lnk.wr;
            next_s.pend_rd = s.pend_rd | !lnk.wr;
          end
        end else begin
          next_s.h_open = !is_end;
          if (is_end) begin
            next_s = finish(next_s, lnk.wr);
          end
        end
      end
    end
    // Master completions wait for the frame check
    if (lnk.frame_end) begin
      if (lnk.fcs_ok && next_s.pend_wr) begin
        next_s = finish(next_s, 1'b1);
      end
      if (lnk.fcs_ok && next_s.pend_rd) begin
        next_s = finish(next_s, 1'b0);
      end
      next_s.pend_wr = 1'b0;
      next_s.pend_rd = 1'b0;
      next_s.m_end_used = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s <= '0;
      s.ctrl <= `BSU_CTRL_RST;
      s.act <= `BSU_ACT_RST;
      s.hctl <= `BSU_HCTL_RST;
      s.wbuf <= `BSU_WBUF_RST;
      s.last <= `BSU_LAST_EMPTY;
      s.rbuf <= `BSU_RBUF_RST;
    end else begin
      s <= next_s;
    end
  end

  // Interrupt is a level while an enabled event stands
  assign lnk.irq = s.ctrl[`BSU_CTRL_IRQ] && (s.wr_evt || s.rd_evt);
  assign lnk.ack = s.ack;
  assign lnk.ok = s.ok;
  assign lnk.rdata = s.rdata;
  assign lnk.act_chg = s.act_chg;
  assign o_wdog_trig = s.wdog;
  assign o_latch_evt = s.latch;
endmodule

// [common/bsu_defines.svh]
// Offsets, bit positions, reset values and bus map of the buffer sync unit.
// Assumes inclusion by bare name from both ends and from the package users.
`ifndef BSU_DEFINES_SVH
`define BSU_DEFINES_SVH

// ----------------------------------------------------------------------
// Configuration block of one unit
// ----------------------------------------------------------------------
`define BSU_CFG_BASE 16'h0800
`define BSU_OFS_START_LO 3'h0
`define BSU_OFS_START_HI 3'h1
`define BSU_OFS_LEN_LO 3'h2
`define BSU_OFS_LEN_HI 3'h3
`define BSU_OFS_CTRL 3'h4
`define BSU_OFS_STAT 3'h5
`define BSU_OFS_ACT 3'h6
`define BSU_OFS_HCTL 3'h7

// Control byte fields
`define BSU_CTRL_MBX 0
`define BSU_CTRL_MWR 2
`define BSU_CTRL_IRQ 4
`define BSU_CTRL_WDG 6
`define BSU_CTRL_LAT 7
// Activation and host control fields
`define BSU_ACT_EN 0
`define BSU_ACT_RPT 1
`define BSU_HCTL_DEACT 0
`define BSU_HCTL_RACK 1
// Status byte fields
`define BSU_STAT_WR 0
`define BSU_STAT_RD 1
`define BSU_STAT_FULL 3
`define BSU_STAT_LAST 4

// Reset values
`define BSU_CTRL_RST 8'h00
`define BSU_ACT_RST 8'h00
`define BSU_HCTL_RST 8'h00
`define BSU_LAST_EMPTY 2'h3
`define BSU_WBUF_RST 2'h0
`define BSU_RBUF_RST 2'h1

// ----------------------------------------------------------------------
// Controller registers on APB (byte addresses)
// ----------------------------------------------------------------------
`define HOST_REG_CMD 8'h00
`define HOST_REG_FRAME 8'h04
`define HOST_REG_STAT 8'h08
`define HOST_REG_WKC 8'h0C

`endif

// [common/bsu_pkg.sv]
// Types shared by both ends of the buffer sync unit link.
// Assumes nothing beyond a SystemVerilog compiler.
package bsu_pkg;

  // Protocol carried in a handshake buffer
  typedef enum logic [3:0] {
    PROTO_ERROR = 4'h0,
    PROTO_VENDOR_CMD = 4'h1,
    PROTO_ETH_TUNNEL = 4'h2,
    PROTO_OBJ_DICT = 4'h3,
    PROTO_FILE = 4'h4,
    PROTO_SERVO = 4'h5,
    PROTO_VENDOR_PROFILE = 4'hF
  } proto_t;

  // Handshake buffer header, bit 0 is length bit 0
  typedef struct packed {
    logic rsvd;
    logic [2:0] seq_ctr;
    proto_t proto;
    logic [1:0] prio;
    logic [5:0] channel;
    logic [15:0] orig_addr;
    logic [15:0] length;
  } mbx_header_t;

  // Which party drives an access on the shared channel
  typedef enum logic {
    SRC_MASTER = 1'b0,
    SRC_HOST = 1'b1
  } src_t;

endpackage

// [common/bsu_link_if.sv]
// Link between the buffer sync unit and its outside parties.
// Assumes one clock shared by both ends; no clocking block.
`timescale 1ns/1ps
interface bsu_link_if (
  input wire logic clk
);
  logic req;
  bsu_pkg::src_t who;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic frame_end;
  logic fcs_ok;
  logic ack;
  logic ok;
  logic [7:0] rdata;
  logic irq;
  logic act_chg;

  modport device (
    input req, who, wr, addr, wdata, frame_end, fcs_ok,
    output ack, ok, rdata, irq, act_chg
  );
  modport ctrl (
    output req, who, wr, addr, wdata, frame_end, fcs_ok,
    input ack, ok, rdata, irq, act_chg
  );
endinterface

// [rtl/bsu_ctrl.sv]
// Outside party: relays APB orders into master and host accesses.
// Assumes software sequences accesses, frames and repeat handling.
`timescale 1ns/1ps
`include "bsu_defines.svh"
module bsu_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  bsu_link_if.ctrl lnk
);
  typedef struct packed {
    logic rdy;
    logic [31:0] prdata;
    logic req;
    logic who;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic frame_end;
    logic fcs_ok;
    logic busy;
    logic ok;
    logic [7:0] rdata;
    logic [15:0] wkc;
  } ctl_st_t;

  ctl_st_t s;
  ctl_st_t next_s;
  logic acc;

  // ----------------------------------------------------------------------
  // APB slave and command relay
  // ----------------------------------------------------------------------
  // Ready comes one cycle into the access so that read data is a flop
  always_comb begin
    next_s = s;
    next_s.req = 1'b0;
    next_s.frame_end = 1'b0;
    acc = i_psel && i_penable && s.rdy;
    next_s.rdy = i_psel && i_penable && !s.rdy;
    if (next_s.rdy) begin
      unique case (i_paddr)
        `HOST_REG_STAT: next_s.prdata = {12'h000, lnk.act_chg, lnk.irq, s.ok, s.busy,
                                         8'h00, s.rdata};
        `HOST_REG_WKC: next_s.prdata = {16'h0000, s.wkc};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
    // Software orders each access, repeat acknowledge and reread itself
    if (acc && i_pwrite && i_paddr == `HOST_REG_CMD && !s.busy) begin
      next_s.req = 1'b1;
      next_s.busy = 1'b1;
      next_s.addr = i_pwdata[15:0];
      next_s.wdata = i_pwdata[23:16];
      next_s.wr = i_pwdata[24];
      next_s.who = i_pwdata[25];
    end
    if (acc && i_pwrite && i_paddr == `HOST_REG_FRAME) begin
      next_s.frame_end = 1'b1;
      next_s.fcs_ok = i_pwdata[0];
    end
    if (acc && i_pwrite && i_paddr == `HOST_REG_WKC) begin
      next_s.wkc = 16'h0000;
    end
    // Master accesses that succeed raise the working counter
    if (lnk.ack) begin
      next_s.busy = 1'b0;
      next_s.ok = lnk.ok;
      next_s.rdata = lnk.rdata;
      if (lnk.ok && s.who == bsu_pkg::SRC_MASTER) begin
        next_s.wkc = s.wkc + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_pready = s.rdy;
  assign o_prdata = s.prdata;
  assign o_pslverr = 1'b0;
  assign lnk.req = s.req;
  assign lnk.who = bsu_pkg::src_t'(s.who);
  assign lnk.wr = s.wr;
  assign lnk.addr = s.addr;
  assign lnk.wdata = s.wdata;
  assign lnk.frame_end = s.frame_end;
  assign lnk.fcs_ok = s.fcs_ok;
endmodule

// [test/bsu_link_chk.sv]
// Checker for the link between controller and buffer sync unit.
// Assumes one clock; the bench places it beside the link interface.
`timescale 1ns/1ps
module bsu_link_chk (
  input wire logic clk,
  input wire logic i_rst,
  input wire logic req,
  input wire bsu_pkg::src_t who,
  input wire logic wr,
  input wire logic frame_end,
  input wire logic fcs_ok,
  input wire logic ack,
  input wire logic irq,
  input wire logic act_chg,
  input wire logic o_wdog_trig,
  input wire logic o_latch_evt
);
  // --------
  // Causes
  // --------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (i_rst);
  // Only a good frame end or a host access may complete a buffer
  wire logic good_end = frame_end && fcs_ok;
  wire logic host_req = req && who == bsu_pkg::SRC_HOST;
  wire logic mst_wr = req && wr && who == bsu_pkg::SRC_MASTER;
  sequence s_lone_req;
    req ##1 !req;
  endsequence
  sequence s_bad_end;
    frame_end && !fcs_ok && !req;
  endsequence
  // --------
  // Properties
  // --------
  a_ack_follows: assert property (req |=> ack)
    else $error("no ack after request");
  a_ack_single: assert property (s_lone_req |=> !ack)
    else $error("ack too long");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_wdog_cause: assert property (o_wdog_trig |-> $past(good_end) || $past(host_req && wr))
    else $error("watchdog pulse without write");
  a_wdog_bad_fcs: assert property (s_bad_end |=> !o_wdog_trig)
    else $error("watchdog pulse after bad frame");
  a_wdog_pulse: assert property (o_wdog_trig |=> !o_wdog_trig)
    else $error("watchdog pulse too long");
  a_latch_cause: assert property (o_latch_evt |-> $past(good_end) || $past(host_req))
    else $error("latch pulse without access");
  a_irq_cause: assert property ($rose(irq) |-> $past(req) || $past(frame_end))
    else $error("irq without cause");
  a_act_chg_cause: assert property ($rose(act_chg) |-> $past(mst_wr) || $past(frame_end))
    else $error("activation event without write");
  a_act_chg_hold: assert property (act_chg && !req && !ack |=> act_chg)
    else $error("activation event lost");
endmodule

// [test/test_buffer_sync_mailbox_extensions.sv]
// Bench: APB orders reach the buffer sync unit through the controller.
// Assumes one command word gives one link access, polled via status.
`timescale 1ns/1ps
`include "bsu_defines.svh"
module test_buffer_sync_mailbox_extensions;
  localparam bsu_pkg::src_t mst = bsu_pkg::SRC_MASTER;
  localparam bsu_pkg::src_t hst = bsu_pkg::SRC_HOST;
  localparam logic [15:0] cb = `BSU_CFG_BASE;
  localparam logic [15:0] ba = 16'h0010;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic wdog;
  logic latch;
  logic [7:0] rd;
  logic [7:0] d [4];
  logic [31:0] sv;
  bsu_pkg::mbx_header_t hdr;
  int fail_count = 0;
  int checks = 0;
  int wdog_n = 0;
  int latch_n = 0;
  int w0;
  int l0;
  integer seed = 39340;

  // 25 MHz clock
  always #20 clk = ~clk;

  bsu_link_if lnk (.clk(clk));
  bsu_ctrl bsu_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(), .lnk(lnk.ctrl));
  bsu_unit #(.DEPTH(64)) bsu_unit_i (.i_core_clk(clk), .i_rst(rst), .o_wdog_trig(wdog),
    .o_latch_evt(latch), .lnk(lnk.device));
  bsu_link_chk bsu_link_chk_i (.clk(clk), .i_rst(rst), .req(lnk.req), .who(lnk.who),
    .wr(lnk.wr), .frame_end(lnk.frame_end), .fcs_ok(lnk.fcs_ok), .ack(lnk.ack),
    .irq(lnk.irq), .act_chg(lnk.act_chg), .o_wdog_trig(wdog), .o_latch_evt(latch));

  // Pulses are counted, so a missing or doubled one shows in the totals
  always @(posedge clk) begin
    if (wdog === 1'b1) wdog_n++;
    if (latch === 1'b1) latch_n++;
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Status byte of a unit with no events standing: full flag and last buffer
  function automatic logic [31:0] stat_exp(input logic full, input logic [1:0] last);
    return {24'h0, 2'b00, last, full, 3'b000};
  endfunction

  // APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One link access, polled until idle; checks accept or refuse
  task automatic xa(input bsu_pkg::src_t s, input logic w, input logic [15:0] a,
      input logic [7:0] wd, input logic eo);
    int n = 0;
    apb(1'b1, `HOST_REG_CMD, {6'h0, s, w, wd, a}, sv);
    do begin
      apb(1'b0, `HOST_REG_STAT, 32'h0, sv);
      n++;
    end while (sv[16] !== 1'b0 && n < 20);
    chk("link idle", 32'h0, {31'h0, sv[16]});
    rd = sv[7:0];
    chk("link ok", {31'h0, eo}, {31'h0, sv[17]});
  endtask

  task automatic cfg(input logic [2:0] o, input logic [7:0] v);
    xa(mst, 1'b1, cb + {13'h0, o}, v, 1'b1);
  endtask

  // Frame end, then time for the events of the next cycle to land
  task automatic frm(input logic g);
    apb(1'b1, `HOST_REG_FRAME, {31'h0, g}, sv);
    repeat (4) @(posedge clk);
  endtask

  task automatic sbit(input string what, input int b, input logic e);
    apb(1'b0, `HOST_REG_STAT, 32'h0, sv);
    chk(what, {31'h0, e}, {31'h0, sv[b]});
  endtask

  task automatic fill();
    for (int i = 0; i < 4; i++) begin
      xa(mst, 1'b1, ba + 16'(i), d[i], 1'b1);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // --------
  // Scenarios
  // --------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 4; i < 8; i++) begin
      xa(hst, 1'b0, cb + 16'(i), 8'h0, 1'b1);
      chk("cfg reset", (i == 5) ? stat_exp(1'b0, 2'h3) : 32'h0, {24'h0, rd});
    end
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, sv);
    apb(1'b0, 8'h10, 32'h0, sv);
    chk("unmapped", 32'h0, sv);
    // Header layout: length lowest, reserved bit on top
    hdr = '0;
    hdr.length = 16'h0004;
    hdr.orig_addr = 16'h1001;
    hdr.prio = 2'h3;
    hdr.proto = bsu_pkg::PROTO_VENDOR_PROFILE;
    hdr.seq_ctr = 3'h7;
    chk("hdr length", 32'h0004, {16'h0, hdr[15:0]});
    chk("hdr address", 32'h1001, {16'h0, hdr[31:16]});
    chk("hdr channel prio", 32'hC0, {24'h0, hdr[39:32]});
    chk("hdr type", 32'hF, {28'h0, hdr[43:40]});
    chk("hdr ctr rsvd", 32'h7, {28'h0, hdr[47:44]});
    chk("type codes", 32'h0012_345F, {4'h0, bsu_pkg::PROTO_ERROR,
        bsu_pkg::PROTO_VENDOR_CMD, bsu_pkg::PROTO_ETH_TUNNEL, bsu_pkg::PROTO_OBJ_DICT,
        bsu_pkg::PROTO_FILE, bsu_pkg::PROTO_SERVO, bsu_pkg::PROTO_VENDOR_PROFILE});
    $display("test reset done");
    // Mailbox, master writes, irq and watchdog on
    cfg(`BSU_OFS_START_LO, 8'h10);
    cfg(`BSU_OFS_LEN_LO, 8'h04);
    cfg(`BSU_OFS_CTRL, 8'h55);
    cfg(`BSU_OFS_ACT, 8'h01);
    frm(1'b1);
    for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
    w0 = wdog_n;
    fill();
    frm(1'b0);
    chk("wdog bad fcs", w0, wdog_n);
    xa(hst, 1'b0, ba, 8'h0, 1'b0);
    fill();
    xa(mst, 1'b1, ba + 16'h3, 8'h0, 1'b0);
    frm(1'b1);
    chk("wdog", w0 + 1, wdog_n);
    sbit("irq", 18, 1'b1);
    xa(hst, 1'b0, cb + 16'h5, 8'h0, 1'b1);
    chk("stat full", 32'h09, {24'h0, rd & 8'h09});
    xa(mst, 1'b1, ba, 8'h0, 1'b0);
    xa(hst, 1'b0, ba + 16'h1, 8'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      xa(hst, 1'b0, ba + 16'(i), 8'h0, 1'b1);
      chk("mailbox data", {24'h0, d[i]}, {24'h0, rd});
    end
    xa(mst, 1'b1, ba, d[0], 1'b1);
    $display("test mailbox done");
    // Host deactivates; master access refused and not counted
    apb(1'b0, `HOST_REG_WKC, 32'h0, sv);
    w0 = sv;
    xa(hst, 1'b1, cb + 16'h7, 8'h01, 1'b1);
    xa(mst, 1'b1, ba + 16'h1, 8'h0, 1'b0);
    xa(hst, 1'b0, ba, 8'h0, 1'b0);
    apb(1'b0, `HOST_REG_WKC, 32'h0, sv);
    chk("wkc", w0, sv);
    sbit("irq deact", 18, 1'b0);
    xa(hst, 1'b0, cb + 16'h5, 8'h0, 1'b1);
    chk("stat deact", stat_exp(1'b0, 2'h3), {24'h0, rd & 8'h38});
    xa(hst, 1'b1, cb + 16'h7, 8'h0, 1'b1);
    xa(hst, 1'b0, ba, 8'h0, 1'b0);
    fill();
    frm(1'b1);
    xa(hst, 1'b0, ba, 8'h0, 1'b1);
    chk("data reactivated", {24'h0, d[0]}, {24'h0, rd});
    $display("test deactivate done");
    // Repeat request toggled both ways, then acknowledged
    xa(hst, 1'b0, cb + 16'h6, 8'h0, 1'b1);
    chk("act", 32'h01, {24'h0, rd});
    sbit("act chg clear", 19, 1'b0);
    xa(mst, 1'b1, cb + 16'h6, 8'h03, 1'b1);
    frm(1'b1);
    sbit("act chg", 19, 1'b1);
    xa(hst, 1'b0, cb + 16'h6, 8'h0, 1'b1);
    chk("repeat req", 32'h03, {24'h0, rd});
    xa(mst, 1'b1, cb + 16'h6, 8'h01, 1'b1);
    frm(1'b1);
    sbit("act chg back", 19, 1'b1);
    xa(hst, 1'b1, cb + 16'h7, 8'h02, 1'b1);
    xa(mst, 1'b0, cb + 16'h7, 8'h0, 1'b1);
    chk("repeat ack", 32'h02, {24'h0, rd});
    $display("test repeat done");
    // Zero length acts disabled
    cfg(`BSU_OFS_LEN_LO, 8'h00);
    frm(1'b1);
    w0 = wdog_n;
    xa(mst, 1'b1, ba, d[3], 1'b1);
    frm(1'b1);
    chk("wdog len0", w0, wdog_n);
    xa(hst, 1'b0, ba, 8'h0, 1'b1);
    chk("data len0", {24'h0, d[3]}, {24'h0, rd});
    $display("test zero length done");
    // Four-byte buffered unit: the reader gets the newest complete buffer
    cfg(`BSU_OFS_LEN_LO, 8'h04);
    cfg(`BSU_OFS_CTRL, 8'h04);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
      fill();
      frm(1'b1);
      xa(hst, 1'b0, cb + 16'h5, 8'h0, 1'b1);
      chk("stat last", stat_exp(1'b0, (k == 0) ? 2'h0 : 2'h2), {24'h0, rd & 8'h30});
      for (int i = 0; i < 4; i++) begin
        xa(hst, 1'b0, ba + 16'(i), 8'h0, 1'b1);
        chk("buffered data", {24'h0, d[i]}, {24'h0, rd});
      end
    end
    $display("test buffered done");
    // One-byte buffered unit with watchdog and latch events
    cfg(`BSU_OFS_LEN_LO, 8'h01);
    cfg(`BSU_OFS_CTRL, 8'hD4);
    frm(1'b1);
    xa(hst, 1'b1, ba + 16'h1, 8'hA5, 1'b1);
    w0 = wdog_n;
    l0 = latch_n;
    for (int i = 0; i < 3; i++) begin
      xa(mst, 1'b1, ba, d[i], 1'b1);
      frm(1'b1);
      xa(hst, 1'b0, ba, 8'h0, 1'b1);
      chk("byte buffer", {24'h0, d[i]}, {24'h0, rd});
    end
    chk("wdog len1", w0 + 3, wdog_n);
    chk("latch", l0 + 6, latch_n);
    xa(hst, 1'b0, ba + 16'h1, 8'h0, 1'b1);
    chk("byte beside", 32'hA5, {24'h0, rd});
    $display("test single byte done");
    close_out();
  end

  // Hang guard: the tests need under a thousand cycles
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule
